/* File: shared/regulator_output_config_pkg.sv */
// register map, field layout and reset values of the regulator output configuration bank
package regulator_output_config_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;
   localparam logic [7:0] SECOND_CONVERTER_VOLTAGE_OFS = 8'h07;
   localparam logic [7:0] LINEAR_REG0_CONTROL_OFS      = 8'h08;
   localparam logic [7:0] LINEAR_REG1_CONTROL_OFS      = 8'h09;
   localparam logic [7:0] LINEAR_REG0_VOLTAGE_OFS      = 8'h0A;
   localparam logic [7:0] LINEAR_REG1_VOLTAGE_OFS      = 8'h0B;
   // control and voltage register fields
   localparam int unsigned RUN_BIT       = 0;
   localparam int unsigned PIN_GATE_BIT  = 1;
   localparam int unsigned DISCHARGE_BIT = 2;
   localparam int unsigned CTRL_RSV_LSB  = 3;
   localparam int unsigned LIN_CODE_W    = 5;
   localparam int unsigned VOLT_RSV_LSB  = 5;
   // reset values
   localparam logic [7:0] SECOND_CONVERTER_VOLTAGE_RST = 8'hA4;
   localparam logic [7:0] LINEAR_REG0_CONTROL_RST      = 8'h07;
   localparam logic [7:0] LINEAR_REG1_CONTROL_RST      = 8'h04;
   localparam logic [7:0] LINEAR_REG0_VOLTAGE_RST      = 8'h19;
   localparam logic [7:0] LINEAR_REG1_VOLTAGE_RST      = 8'h02;
   // code range limits, levels and steps
   localparam logic [7:0] CONV_CODE_MIN    = 8'h14;
   localparam logic [7:0] CONV_FINE_LAST   = 8'h17;
   localparam logic [7:0] CONV_MID_LAST    = 8'h9D;
   localparam logic [4:0] LIN_CODE_MAX     = 5'h19;
   localparam int unsigned CONV_BASE_MV    = 700;
   localparam int unsigned CONV_MID_MV     = 735;
   localparam int unsigned CONV_HIGH_MV    = 1420;
   localparam int unsigned CONV_FINE_STEP  = 10;
   localparam int unsigned CONV_MID_STEP   = 5;
   localparam int unsigned CONV_HIGH_STEP  = 20;
   localparam int unsigned LIN_BASE_MV     = 800;
   localparam int unsigned LIN_STEP_MV     = 100;
endpackage : regulator_output_config_pkg

/* File: hw/regulator_output_config_regs.sv */
// regulator output configuration register bank with enable pin gating
`timescale 1ns/1ps
module regulator_output_config_regs
(
   input  wire logic                                         clk_i,
   input  wire logic                                         rst_b_i,
   input  wire logic                                         wr_en_i,
   input  wire logic                                         rd_en_i,
   input  wire logic [regulator_output_config_pkg::ADDR_W-1:0] addr_i,
   input  wire logic [regulator_output_config_pkg::DATA_W-1:0] wdata_i,
   input  wire logic                                         enable_pin_i,
   output logic      [regulator_output_config_pkg::DATA_W-1:0] rdata_o,
   output logic                                              rvalid_o,
   output logic      [7:0]                                   second_converter_voltage_code_o,
   output logic      [11:0]                                  second_converter_mv_o,
   output logic                                              lin0_on_o,
   output logic                                              lin1_on_o,
   output logic                                              lin0_discharge_o,
   output logic                                              lin1_discharge_o,
   output logic      [4:0]                                   lin0_voltage_code_o,
   output logic      [4:0]                                   lin1_voltage_code_o,
   output logic      [11:0]                                  lin0_mv_o,
   output logic      [11:0]                                  lin1_mv_o
);
   import regulator_output_config_pkg::*;

   typedef struct packed {
      logic [7:0]  conv_code;
      logic [7:0]  lin0_ctrl;
      logic [7:0]  lin1_ctrl;
      logic [7:0]  lin0_volt;
      logic [7:0]  lin1_volt;
      logic [7:0]  rdata;
      logic        rvalid;
      logic        lin0_on;
      logic        lin1_on;
      logic        lin0_dis;
      logic        lin1_dis;
      logic [11:0] conv_mv;
      logic [11:0] lin0_mv;
      logic [11:0] lin1_mv;
   } state_t;

   logic   rst_sync1_q;
   logic   rst_sync2_q;
   state_t s_q;
   state_t s_d;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_sync1_q <= 1'b0;
         rst_sync2_q <= 1'b0;
      end else begin
         rst_sync1_q <= 1'b1;
         rst_sync2_q <= rst_sync1_q;
      end
   end

   // converter code to millivolts
   function automatic logic [11:0] conv_to_mv(input logic [7:0] code);
      logic [11:0] mv;
      mv = '0;
      if (code < CONV_CODE_MIN) begin
         mv = 12'(CONV_BASE_MV); // reserved codes clamp to lowest level
      end else if (code <= CONV_FINE_LAST) begin
         mv = 12'(CONV_BASE_MV + CONV_FINE_STEP * (32'(code) - 32'(CONV_CODE_MIN)));
      end else if (code <= CONV_MID_LAST) begin
         mv = 12'(CONV_MID_MV + CONV_MID_STEP * (32'(code) - 32'(CONV_FINE_LAST) - 1));
      end else begin
         mv = 12'(CONV_HIGH_MV + CONV_HIGH_STEP * (32'(code) - 32'(CONV_MID_LAST) - 1));
      end
      return mv;
   endfunction : conv_to_mv

   function automatic logic [11:0] lin_to_mv(input logic [4:0] code);
      logic [4:0] c;
      c = (code > LIN_CODE_MAX) ? LIN_CODE_MAX : code; // reserved codes clamp
      return 12'(LIN_BASE_MV + LIN_STEP_MV * 32'(c));
   endfunction : lin_to_mv

   function automatic logic lin_run(input logic [7:0] ctrl, input logic pin);
      if (ctrl[PIN_GATE_BIT]) begin
         return ctrl[RUN_BIT] & pin;
      end else begin
         return ctrl[RUN_BIT];
      end
   endfunction : lin_run

   // derived outputs match the reset registers with enable_pin_i low: both regulators off, discharge per bit
   localparam state_t STATE_RST = '{
      conv_code: SECOND_CONVERTER_VOLTAGE_RST,
      lin0_ctrl: LINEAR_REG0_CONTROL_RST,
      lin1_ctrl: LINEAR_REG1_CONTROL_RST,
      lin0_volt: LINEAR_REG0_VOLTAGE_RST,
      lin1_volt: LINEAR_REG1_VOLTAGE_RST,
      lin0_dis:  LINEAR_REG0_CONTROL_RST[DISCHARGE_BIT],
      lin1_dis:  LINEAR_REG1_CONTROL_RST[DISCHARGE_BIT],
      conv_mv:   conv_to_mv(SECOND_CONVERTER_VOLTAGE_RST),
      lin0_mv:   lin_to_mv(LINEAR_REG0_VOLTAGE_RST[LIN_CODE_W-1:0]),
      lin1_mv:   lin_to_mv(LINEAR_REG1_VOLTAGE_RST[LIN_CODE_W-1:0]),
      default:   '0
   };

   always_comb begin
      s_d = s_q;
      s_d.rvalid = 1'b0;
      if (wr_en_i) begin
         case (addr_i)
            SECOND_CONVERTER_VOLTAGE_OFS: s_d.conv_code = wdata_i;
            LINEAR_REG0_CONTROL_OFS:      s_d.lin0_ctrl = wdata_i;
            LINEAR_REG1_CONTROL_OFS:      s_d.lin1_ctrl = wdata_i;
            LINEAR_REG0_VOLTAGE_OFS:      s_d.lin0_volt = wdata_i;
            LINEAR_REG1_VOLTAGE_OFS:      s_d.lin1_volt = wdata_i;
            default: ;
         endcase
      end
      if (rd_en_i) begin
         s_d.rvalid = 1'b1;
         case (addr_i)
            SECOND_CONVERTER_VOLTAGE_OFS: s_d.rdata = s_q.conv_code;
            LINEAR_REG0_CONTROL_OFS:      s_d.rdata = s_q.lin0_ctrl;
            LINEAR_REG1_CONTROL_OFS:      s_d.rdata = s_q.lin1_ctrl;
            LINEAR_REG0_VOLTAGE_OFS:      s_d.rdata = s_q.lin0_volt;
            LINEAR_REG1_VOLTAGE_OFS:      s_d.rdata = s_q.lin1_volt;
            default:                      s_d.rdata = 8'h00;
         endcase
      end
      s_d.lin0_on  = lin_run(s_d.lin0_ctrl, enable_pin_i);
      s_d.lin1_on  = lin_run(s_d.lin1_ctrl, enable_pin_i);
      s_d.lin0_dis = s_d.lin0_ctrl[DISCHARGE_BIT] & ~s_d.lin0_on;
      s_d.lin1_dis = s_d.lin1_ctrl[DISCHARGE_BIT] & ~s_d.lin1_on;
      s_d.conv_mv  = conv_to_mv(s_d.conv_code);
      s_d.lin0_mv  = lin_to_mv(s_d.lin0_volt[LIN_CODE_W-1:0]);
      s_d.lin1_mv  = lin_to_mv(s_d.lin1_volt[LIN_CODE_W-1:0]);
   end

   always_ff @(posedge clk_i or negedge rst_sync2_q) begin
      if (!rst_sync2_q) begin
         s_q <= STATE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata_o                         = s_q.rdata;
   assign rvalid_o                        = s_q.rvalid;
   assign second_converter_voltage_code_o = s_q.conv_code;
   assign second_converter_mv_o           = s_q.conv_mv;
   assign lin0_on_o                       = s_q.lin0_on;
   assign lin1_on_o                       = s_q.lin1_on;
   assign lin0_discharge_o                = s_q.lin0_dis;
   assign lin1_discharge_o                = s_q.lin1_dis;
   assign lin0_voltage_code_o             = s_q.lin0_volt[LIN_CODE_W-1:0];
   assign lin1_voltage_code_o             = s_q.lin1_volt[LIN_CODE_W-1:0];
   assign lin0_mv_o                       = s_q.lin0_mv;
   assign lin1_mv_o                       = s_q.lin1_mv;

   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_sync2_q);

   sequence wr_conv_s;
      wr_en_i && addr_i == SECOND_CONVERTER_VOLTAGE_OFS;
   endsequence

   chk_conv_code_write: assert property (
      wr_conv_s |=> second_converter_voltage_code_o == $past(wdata_i))
      else $error("converter code not stored");
   chk_conv_fine_range: assert property (
      second_converter_voltage_code_o == 8'h15 |-> second_converter_mv_o == 12'h2c6)
      else $error("fine range level wrong");
   chk_conv_mid_range: assert property (
      second_converter_voltage_code_o == 8'h9D |-> second_converter_mv_o == 12'h578)
      else $error("mid range level wrong");
   chk_conv_high_range: assert property (
      second_converter_voltage_code_o == 8'hFF |-> second_converter_mv_o == 12'hd20)
      else $error("high range level wrong");
   chk_lin_discharge: assert property (
      lin0_discharge_o == (s_q.lin0_ctrl[DISCHARGE_BIT] && !lin0_on_o))
      else $error("discharge state wrong");
   chk_pin_ignored: assert property (
      !s_q.lin1_ctrl[PIN_GATE_BIT] && !wr_en_i && $stable(s_q.lin1_ctrl)
      |=> lin1_on_o == $past(s_q.lin1_ctrl[RUN_BIT]))
      else $error("pin not ignored");
   chk_pin_gating: assert property (
      s_q.lin0_ctrl[PIN_GATE_BIT] && !enable_pin_i && !wr_en_i |=> !lin0_on_o)
      else $error("gated regulator ran without pin");
   chk_lin_voltage: assert property (
      lin0_voltage_code_o == 5'h19 |-> lin0_mv_o == 12'hce4)
      else $error("linear level wrong");
   chk_reset_values: assert property (
      $rose(rst_sync2_q) |-> s_q.lin1_ctrl == LINEAR_REG1_CONTROL_RST && !lin1_on_o)
      else $error("reset state wrong");

   sequence rd_req_s;
      rd_en_i;
   endsequence

   sequence wr_lin0_volt_s;
      wr_en_i && addr_i == LINEAR_REG0_VOLTAGE_OFS;
   endsequence

   chk_read_answer: assert property (
      rd_req_s |=> rvalid_o)
      else $error("read not answered");
   chk_conv_fine_low: assert property (
      second_converter_voltage_code_o == CONV_CODE_MIN |-> second_converter_mv_o == 12'h2bc)
      else $error("lowest level wrong");
   chk_lin1_discharge: assert property (
      lin1_discharge_o == (s_q.lin1_ctrl[DISCHARGE_BIT] && !lin1_on_o))
      else $error("second discharge state wrong");
   chk_lin0_code_write: assert property (
      wr_lin0_volt_s |=> lin0_voltage_code_o == 5'($past(wdata_i)))
      else $error("linear code not stored");
   chk_lin0_reset: assert property (
      $rose(rst_sync2_q) |-> s_q.lin0_ctrl == LINEAR_REG0_CONTROL_RST
                             && s_q.lin0_volt == LINEAR_REG0_VOLTAGE_RST)
      else $error("first linear reset wrong");
   chk_lin1_volt_reset: assert property (
      $rose(rst_sync2_q) |-> s_q.lin1_volt == LINEAR_REG1_VOLTAGE_RST
                             && second_converter_voltage_code_o == SECOND_CONVERTER_VOLTAGE_RST)
      else $error("second linear reset wrong");
endmodule : regulator_output_config_regs

/* File: dv/tb.sv */
// self-checking bench for the regulator output configuration bank
`timescale 1ns/1ps
module tb;
   import regulator_output_config_pkg::*;
   logic        clk_i        = 1'b0;
   logic        rst_b_i      = 1'b0;
   logic        wr_en_i      = 1'b0;
   logic        rd_en_i      = 1'b0;
   logic [7:0]  addr_i       = 8'h00;
   logic [7:0]  wdata_i      = 8'h00;
   logic        enable_pin_i = 1'b0;
   logic [7:0]  rdata_o;
   logic [7:0]  conv_code;
   logic        rvalid_o;
   logic        lin0_on;
   logic        lin1_on;
   logic        lin0_dis;
   logic        lin1_dis;
   logic [11:0] conv_mv;
   logic [11:0] lin0_mv;
   logic [11:0] lin1_mv;
   logic [4:0]  lin0_code;
   logic [4:0]  lin1_code;
   logic [7:0]  shadow [7:11];
   logic [7:0]  exp_q [$];
   int          n_mismatch = 0;
   int          n_compared = 0;
   always #25 clk_i = ~clk_i;
   regulator_output_config_regs dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .wr_en_i(wr_en_i),
      .rd_en_i(rd_en_i), .addr_i(addr_i), .wdata_i(wdata_i), .enable_pin_i(enable_pin_i),
      .rdata_o(rdata_o), .rvalid_o(rvalid_o), .second_converter_voltage_code_o(conv_code),
      .second_converter_mv_o(conv_mv), .lin0_on_o(lin0_on), .lin1_on_o(lin1_on),
      .lin0_discharge_o(lin0_dis), .lin1_discharge_o(lin1_dis),
      .lin0_voltage_code_o(lin0_code), .lin1_voltage_code_o(lin1_code),
      .lin0_mv_o(lin0_mv), .lin1_mv_o(lin1_mv));
   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check
   task automatic conclude();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : conclude
   function automatic logic [11:0] conv_exp(input logic [7:0] c);
      if (c <= 8'h17) return 12'(700 + 10 * (c - 8'h14));
      if (c <= 8'h9d) return 12'(735 + 5 * (c - 8'h18));
      return 12'(1420 + 20 * (c - 8'h9e));
   endfunction : conv_exp
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      wr_en_i <= 1'b1;
      addr_i  <= a;
      wdata_i <= d;
      if (a >= 8'h07 && a <= 8'h0b) shadow[a] = d;
      @(negedge clk_i);
      wr_en_i <= 1'b0;
   endtask : wr
   // back-to-back reads of the whole map plus two unmapped places
   task automatic rd_all();
      for (int a = 6; a <= 12; a++) begin
         @(negedge clk_i);
         rd_en_i <= 1'b1;
         addr_i  <= 8'(a);
         exp_q.push_back((a >= 7 && a <= 11) ? shadow[a] : 8'h00);
      end
      @(negedge clk_i);
      rd_en_i <= 1'b0;
   endtask : rd_all
   task automatic outs();
      logic on0;
      logic on1;
      on0 = shadow[8][0] & (enable_pin_i | ~shadow[8][1]);
      on1 = shadow[9][0] & (enable_pin_i | ~shadow[9][1]);
      check(12'(lin0_on), 12'(on0));
      check(12'(lin1_on), 12'(on1));
      check(12'(lin0_dis), 12'(shadow[8][2] & ~on0));
      check(12'(lin1_dis), 12'(shadow[9][2] & ~on1));
      check(12'(conv_code), 12'(shadow[7]));
      check(conv_mv, conv_exp(shadow[7]));
      check(12'(lin0_code), 12'(shadow[10][4:0]));
      check(12'(lin1_code), 12'(shadow[11][4:0]));
      check(lin0_mv, 12'(800 + 100 * shadow[10][4:0]));
      check(lin1_mv, 12'(800 + 100 * shadow[11][4:0]));
   endtask : outs
   always @(negedge clk_i) begin
      if (rvalid_o === 1'b1) begin
         if (exp_q.size() == 0) check(12'(rdata_o), 12'hfff);
         else check(12'(rdata_o), 12'(exp_q.pop_front()));
      end
   end
   initial begin
      #(50 * 20000);
      n_mismatch++;
      conclude();
   end
   initial begin
      logic [7:0] codes [6];
      void'($urandom(90));
      codes = '{8'h14, 8'h17, 8'h18, 8'h9d, 8'h9e, 8'hff};
      for (int r = 0; r < 2; r++) begin
         shadow = '{8'ha4, 8'h07, 8'h04, 8'h19, 8'h02};
         rst_b_i <= 1'b0;
         repeat (12) @(negedge clk_i);
         rst_b_i <= 1'b1;
         repeat (4) @(negedge clk_i);
         outs();
         rd_all();
         if (r == 0) begin
            wr(8'h09, 8'h03);
            outs();
         end
      end
      wr(8'h0c, 8'h55);
      rd_all();
      for (int i = 0; i < 32; i++) begin
         wr(8'h08 + 8'(i / 16), 8'(i % 8));
         enable_pin_i <= i[3];
         @(negedge clk_i);
         outs();
      end
      foreach (codes[k]) begin
         wr(8'h07, codes[k]);
         wr(8'h0a + 8'(k % 2), 8'((k % 2) * 25));
         outs();
      end
      repeat (20) begin
         wr(8'h07, 8'h14 + 8'($urandom_range(235)));
         wr(8'h0a, 8'($urandom_range(25)));
         wr(8'h0b, 8'($urandom_range(25)));
         enable_pin_i <= 1'($urandom_range(1));
         @(negedge clk_i);
         outs();
         rd_all();
      end
      repeat (3) @(negedge clk_i);
      check(12'(exp_q.size()), 12'h000);
      conclude();
   end
endmodule : tb
